// ---- ahbpw_pkg.sv ----
package ahbpw_pkg;
  localparam logic [31:0] ADDR_IN1   = 32'h4003_0800;
  localparam logic [31:0] ADDR_IN2   = 32'h4003_0804;
  localparam logic [31:0] ADDR_OUT1  = 32'h4003_0810;
  localparam logic [31:0] ADDR_OUT2  = 32'h4003_0814;
  localparam logic [31:0] ADDR_IEN   = 32'h4003_0820;
  localparam logic [31:0] ADDR_IST   = 32'h4003_0824;
  localparam logic [31:0] ADDR_BUS   = 32'h4003_0830;
  localparam logic [31:0] ADDR_SETUP = 32'h4003_0834;

  localparam logic [31:0] RST_VAL    = 32'h0000_0000;
  localparam logic [31:0] IN_WMASK   = 32'hf000_01c3;
  localparam logic [31:0] OUT1_WMASK = 32'hffff_f80e;
  localparam logic [31:0] OUT2_WMASK = 32'hffff_002e;
  localparam logic [31:0] IEN_WMASK  = 32'h000b_303f;
  localparam logic [31:0] HOST_MASK  = 32'h000b_0000;
  localparam logic [31:0] W1C_MASK   = 32'h0000_303f;
  localparam logic [31:0] BUS_WMASK  = 32'h0002_0087;
  localparam logic [31:0] SETUP_WMASK = 32'h0000_0e00;
  localparam logic [31:0] WIN1_MASK_BASE = 32'hf000_0000;

  localparam int END_HI = 8;
  localparam int END_LO = 6;
  localparam int CMD_HI = 3;
  localparam int CMD_LO = 1;
  localparam int OUT1_LO = 11;
  localparam int OUT2_LO = 16;
  localparam int SPAN_HI = 11;
  localparam int SPAN_LO = 10;
  localparam int OPEN_BIT = 9;
  localparam int SLV_WAIT_BIT = 17;
  localparam int REQ_DROP_BIT = 7;
  localparam int WR_BURST_BIT = 2;
  localparam int NARROW_BIT = 1;
  localparam int GAP_BIT = 0;
  localparam int FLG_WAKE = 19;
  localparam int FLG_IRQ_B = 17;
  localparam int FLG_IRQ_A = 16;
  localparam int FLG_IN2_ERR = 13;
  localparam int FLG_IN1_ERR = 12;
  localparam int FLG_SERR_SEEN = 5;
  localparam int FLG_SERR_DRV = 4;
  localparam int FLG_PERR = 3;
  localparam int FLG_MABORT = 2;
  localparam int FLG_TABORT_M = 1;
  localparam int FLG_TABORT_T = 0;

  localparam logic [1:0] PREFETCH_ON = 2'b11;
  localparam logic [4:0] PREFETCH_BEATS = 5'h10;
  localparam logic [2:0] CMD_CONFIG = 3'b101;
  localparam logic [2:0] CMD_MEMORY = 3'b011;

  typedef enum logic [2:0] {
    AHBPW_END_NONE  = 3'b000,
    AHBPW_END_TYPE  = 3'b001,
    AHBPW_END_BYTE  = 3'b010,
    AHBPW_END_HALF  = 3'b011,
    AHBPW_END_ADDR  = 3'b100
  } ahbpw_endian_t;

  localparam logic [2:0] HBURST_SINGLE = 3'b000;
  localparam logic [2:0] HBURST_INCR   = 3'b001;
  localparam logic [2:0] HBURST_INCR4  = 3'b011;
  localparam logic [2:0] HBURST_INCR8  = 3'b101;
  localparam logic [2:0] HBURST_INCR16 = 3'b111;
  localparam logic [1:0] HTRANS_IDLE   = 2'b00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage

// ---- ahbpw_ctrl.sv ----
`timescale 1ns/1ps
module ahbpw_ctrl (
  input  wire  logic                 ref_clk,
  input  wire  logic                 nrst,
  input  wire  logic                 ce,
  input  wire  logic [31:0]          reg_addr,
  input  wire  logic [31:0]          reg_wdata,
  input  wire  logic                 reg_wr,
  input  wire  logic                 reg_rd,
  output logic       [31:0]          reg_rdata,
  input  wire  logic                 pci_clk,
  input  wire  logic                 host_wake_n,
  input  wire  logic                 host_irq_a_n,
  input  wire  logic                 host_irq_b_n,
  input  wire  logic                 serr_in_n,
  input  wire  logic                 serr_drive,
  input  wire  logic                 perr_in_n,
  input  wire  logic                 perr_drive,
  input  wire  logic                 master_abort,
  input  wire  logic                 tabort_master,
  input  wire  logic                 tabort_target,
  input  wire  logic                 in_bus_err,
  input  wire  logic                 in_bus_err_win2,
  output logic                       irq,
  input  wire  logic                 in_req,
  input  wire  logic                 in_win2,
  input  wire  logic [31:0]          in_addr,
  output logic                       in_ack,
  output logic                       in_ok,
  output logic       [31:0]          in_ahb_addr,
  output ahbpw_pkg::ahbpw_endian_t   in_endian,
  output logic       [4:0]           in_max_beats,
  input  wire  logic                 ob_req,
  input  wire  logic                 ob_win2,
  input  wire  logic [31:0]          ob_addr,
  output logic                       ob_ack,
  output logic                       ob_ok,
  output logic       [31:0]          ob_pci_addr,
  output logic       [2:0]           ob_cmd,
  input  wire  logic                 s_busy,
  output logic                       s_hready,
  input  wire  logic                 m_start,
  input  wire  logic [4:0]           m_beats,
  input  wire  logic [2:0]           m_size,
  input  wire  logic                 m_want,
  input  wire  logic                 m_more,
  input  wire  logic                 hgrant,
  input  wire  logic                 hready,
  output logic                       hbusreq,
  output logic       [1:0]           htrans,
  output logic       [2:0]           hburst
);
  import ahbpw_pkg::*;

  logic [31:0] in1_ctl;
  logic [31:0] in2_ctl;
  logic [31:0] out1_ctl;
  logic [31:0] out2_ctl;
  logic [31:0] irq_en;
  logic [31:0] flags;
  logic [31:0] bus_ctl;
  logic [31:0] setup;
  logic [31:0] status_view;
  logic [31:0] next_flags;
  logic [31:0] evt;
  logic [31:0] w1c;
  logic [10:0] sync1;
  logic [10:0] sync2;
  logic        pci_clk_d;
  logic        pci_rise;
  logic [31:0] win1_mask;
  logic [31:0] in_ctl;
  logic        in_open;
  logic        next_hbusreq;
  logic [2:0]  next_hburst;

  // Register writes. Masks keep read-only and reserved bits at zero.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      in1_ctl  <= RST_VAL;
      in2_ctl  <= RST_VAL;
      out1_ctl <= RST_VAL;
      out2_ctl <= RST_VAL;
      irq_en   <= RST_VAL;
      bus_ctl  <= RST_VAL;
      setup    <= RST_VAL;
    end else if (ce && reg_wr) begin
      unique case (reg_addr)
        ADDR_IN1:   in1_ctl  <= reg_wdata & IN_WMASK;
        ADDR_IN2:   in2_ctl  <= reg_wdata & IN_WMASK;
        ADDR_OUT1:  out1_ctl <= reg_wdata & OUT1_WMASK;
        ADDR_OUT2:  out2_ctl <= reg_wdata & OUT2_WMASK;
        ADDR_IEN:   irq_en   <= reg_wdata & IEN_WMASK;
        ADDR_BUS:   bus_ctl  <= reg_wdata & BUS_WMASK;
        ADDR_SETUP: setup    <= reg_wdata & SETUP_WMASK;
        default: ;
      endcase
    end
  end

  // Every pin-side input passes two flops before use.
  // Reset shows every line idle: active-low pins high, the rest low.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sync1 <= 11'h57;
      sync2 <= 11'h57;
    end else if (ce) begin
      sync1 <= {perr_drive, tabort_target, tabort_master, master_abort,
                perr_in_n, serr_drive, serr_in_n, pci_clk,
                host_irq_b_n, host_irq_a_n, host_wake_n};
      sync2 <= sync1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pci_clk_d <= 1'b0;
    end else if (ce) begin
      pci_clk_d <= sync2[3];
    end
  end

  // Link events are sampled once per link clock rise, so a level held for a
  // link cycle counts as one event and a flag cleared meanwhile sets again.
  assign pci_rise = sync2[3] && !pci_clk_d;

  always_comb begin
    evt = '0;
    evt[FLG_IN2_ERR]   = in_bus_err && in_bus_err_win2;
    evt[FLG_IN1_ERR]   = in_bus_err && !in_bus_err_win2;
    evt[FLG_SERR_SEEN] = pci_rise && !sync2[4];
    evt[FLG_SERR_DRV]  = pci_rise && sync2[5];
    evt[FLG_PERR]      = pci_rise && (!sync2[6] || sync2[10]);
    evt[FLG_MABORT]    = pci_rise && sync2[7];
    evt[FLG_TABORT_M]  = pci_rise && sync2[8];
    evt[FLG_TABORT_T]  = pci_rise && sync2[9];
  end

  // Writing 0 leaves a flag alone; a same-cycle event beats the clear.
  assign w1c = (ce && reg_wr && reg_addr == ADDR_IST) ? (reg_wdata & W1C_MASK) : '0;

  always_comb begin
    next_flags = ((flags & ~w1c) | evt) & W1C_MASK;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      flags <= RST_VAL;
    end else if (ce) begin
      flags <= next_flags;
    end
  end

  // Host lines are mirrored, never latched; only the host can clear them.
  always_comb begin
    status_view = flags;
    status_view[FLG_WAKE]  = !sync2[0];
    status_view[FLG_IRQ_B] = !sync2[2];
    status_view[FLG_IRQ_A] = !sync2[1];
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(status_view & irq_en);
    end
  end

  // Read data stands in the cycle after the strobe only.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      reg_rdata <= RST_VAL;
    end else if (ce) begin
      reg_rdata <= RST_VAL;
      if (reg_rd) begin
        unique case (reg_addr)
          ADDR_IN1:   reg_rdata <= in1_ctl;
          ADDR_IN2:   reg_rdata <= in2_ctl;
          ADDR_OUT1:  reg_rdata <= out1_ctl;
          ADDR_OUT2:  reg_rdata <= out2_ctl;
          ADDR_IEN:   reg_rdata <= irq_en;
          ADDR_IST:   reg_rdata <= status_view;
          ADDR_BUS:   reg_rdata <= bus_ctl;
          ADDR_SETUP: reg_rdata <= setup;
          default:    reg_rdata <= RST_VAL;
        endcase
      end
    end
  end

  // Inbound translation. A prohibited byte-order code refuses the access,
  // since the data path has no defined ordering for it.
  assign win1_mask = WIN1_MASK_BASE << setup[SPAN_HI:SPAN_LO];
  assign in_ctl    = in_win2 ? in2_ctl : in1_ctl;
  assign in_open   = !in_win2 || setup[OPEN_BIT];

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      in_ack       <= 1'b0;
      in_ok        <= 1'b0;
      in_ahb_addr  <= RST_VAL;
      in_endian    <= AHBPW_END_NONE;
      in_max_beats <= 5'h1;
    end else if (ce) begin
      in_ack <= in_req;
      if (in_req) begin
        in_ok <= in_open && (in_ctl[END_HI:END_LO] <= AHBPW_END_ADDR);
        if (in_win2) begin
          in_ahb_addr <= (in_ctl & WIN1_MASK_BASE) | (in_addr & ~WIN1_MASK_BASE);
        end else begin
          in_ahb_addr <= (in_ctl & win1_mask) | (in_addr & ~win1_mask);
        end
        in_endian <= ahbpw_endian_t'(in_ctl[END_HI:END_LO]);
        in_max_beats <= (in_ctl[1:0] == PREFETCH_ON) ? PREFETCH_BEATS : 5'h1;
      end
    end
  end

  // Outbound translation; window 1 takes only the config code, window 2 only the memory code.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ob_ack      <= 1'b0;
      ob_ok       <= 1'b0;
      ob_pci_addr <= RST_VAL;
      ob_cmd      <= 3'h0;
    end else if (ce) begin
      ob_ack <= ob_req;
      if (ob_req && ob_win2) begin
        ob_pci_addr <= {out2_ctl[31:OUT2_LO], ob_addr[OUT2_LO-1:0]};
        ob_cmd      <= out2_ctl[CMD_HI:CMD_LO];
        ob_ok       <= out2_ctl[CMD_HI:CMD_LO] == CMD_MEMORY;
      end else if (ob_req) begin
        ob_pci_addr <= {out1_ctl[31:OUT1_LO], ob_addr[OUT1_LO-1:0]};
        ob_cmd      <= out1_ctl[CMD_HI:CMD_LO];
        ob_ok       <= out1_ctl[CMD_HI:CMD_LO] == CMD_CONFIG;
      end
    end
  end

  // Slave side: waits are shown by ready low only in the documented mode.
  assign s_hready = !(s_busy && bus_ctl[SLV_WAIT_BIT]);

  // Burst choice for the master side.
  always_comb begin
    next_hburst = HBURST_SINGLE;
    if (bus_ctl[NARROW_BIT] && m_size < 3'h2) begin
      next_hburst = HBURST_SINGLE;
    end else if (bus_ctl[WR_BURST_BIT]) begin
      if (m_beats >= 5'h10) begin
        next_hburst = HBURST_INCR16;
      end else if (m_beats >= 5'h8) begin
        next_hburst = HBURST_INCR8;
      end else if (m_beats >= 5'h4) begin
        next_hburst = HBURST_INCR4;
      end else if (m_beats >= 5'h2) begin
        next_hburst = HBURST_INCR;
      end
    end
  end

  // Request drops on the first granted ready cycle, unless another transfer
  // follows and gap mode keeps the bus held.
  always_comb begin
    next_hbusreq = m_want;
    if (bus_ctl[REQ_DROP_BIT] && hbusreq && hgrant && hready) begin
      next_hbusreq = bus_ctl[GAP_BIT] && m_more;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      hbusreq <= 1'b0;
      htrans  <= HTRANS_IDLE;
      hburst  <= HBURST_SINGLE;
    end else if (ce) begin
      hbusreq <= next_hbusreq;
      htrans  <= (m_start && hgrant && hready) ? HTRANS_NONSEQ : HTRANS_IDLE;
      if (m_start) begin
        hburst <= next_hburst;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  flag_set_wins_a: assert property (
    ce && in_bus_err && !in_bus_err_win2 |=> flags[FLG_IN1_ERR])
    else $error("bus error flag lost");
  flag_clear_a: assert property (
    ce && !evt[FLG_MABORT] && w1c[FLG_MABORT] |=> !flags[FLG_MABORT])
    else $error("abort flag not cleared");
  flag_hold_a: assert property (
    ce && flags[FLG_SERR_DRV] && !w1c[FLG_SERR_DRV] |=> flags[FLG_SERR_DRV])
    else $error("flag dropped without clear");
  host_mirror_a: assert property (
    $past(nrst) && $past(nrst, 2) && $past(ce) && $past(ce, 2)
    |-> status_view[FLG_IRQ_A] == !$past(host_irq_a_n, 2))
    else $error("host line not mirrored");
  irq_follow_a: assert property (
    ce && (flags & irq_en) != '0 |=> irq)
    else $error("enabled flag without interrupt");
  win2_closed_a: assert property (
    ce && in_req && in_win2 && !setup[OPEN_BIT] |=> in_ack && !in_ok)
    else $error("closed window accepted");
  win1_span_a: assert property (
    ce && in_req && !in_win2 && setup[SPAN_HI:SPAN_LO] == 2'b11
    |=> in_ahb_addr[30:0] == $past(in_addr[30:0]))
    else $error("2 GB window kept too many bits");
  ob_cmd_a: assert property (
    ce && ob_req && ob_win2 |=> ob_ok == (ob_cmd == CMD_MEMORY))
    else $error("outbound cycle code check wrong");
  narrow_single_a: assert property (
    ce && m_start && bus_ctl[NARROW_BIT] && m_size < 3'h2 |=> hburst == HBURST_SINGLE)
    else $error("narrow transfer burst");
  req_drop_a: assert property (
    ce && bus_ctl[REQ_DROP_BIT] && !m_more && hbusreq && hgrant && hready
    |=> !hbusreq)
    else $error("request not dropped");
  slave_wait_a: assert property (
    bus_ctl[SLV_WAIT_BIT] && s_busy |-> !s_hready)
    else $error("slave did not wait");
  // Translation answers are checked one cycle after the request that asked.
  bad_order_a: assert property (
    ce && in_req && in_ctl[END_HI:END_LO] > AHBPW_END_ADDR |=> in_ack && !in_ok)
    else $error("prohibited byte order accepted");
  prefetch_len_a: assert property (
    ce && in_req && in_ctl[1:0] == PREFETCH_ON |=> in_max_beats == PREFETCH_BEATS)
    else $error("prefetch length wrong");
  ob_config_a: assert property (
    ce && ob_req && !ob_win2 |=> ob_ok == (ob_cmd == CMD_CONFIG))
    else $error("config cycle code check wrong");
  ob_low_bits_a: assert property (
    ce && ob_req && ob_win2 |=> ob_pci_addr[15:0] == $past(ob_addr[15:0]))
    else $error("outbound low bits lost");
  en_reset_a: assert property (
    $rose(nrst) |-> irq_en == RST_VAL)
    else $error("enables not cleared by reset");
  irq_quiet_a: assert property (
    ce && (status_view & irq_en) == RST_VAL |=> !irq)
    else $error("interrupt without enabled flag");
  wake_mirror_a: assert property (
    $past(nrst) && $past(nrst, 2) && $past(ce) && $past(ce, 2)
    |-> status_view[FLG_WAKE] == !$past(host_wake_n, 2))
    else $error("wake line not mirrored");

  prefetch_c: cover property (ce && in_req ##1 in_max_beats == PREFETCH_BEATS);
  abort_irq_c: cover property (evt[FLG_MABORT] ##[1:3] irq);
  incr16_c: cover property (ce && m_start ##1 hburst == HBURST_INCR16);
  clear_race_c: cover property (ce && evt[FLG_PERR] && w1c[FLG_PERR]);
endmodule

// ---- ahbpw_host_model.sv ----
`timescale 1ns/1ps
module ahbpw_host_model (
  input  wire logic [9:0] ev,
  output logic            pci_clk,
  output logic            host_wake_n,
  output logic            host_irq_a_n,
  output logic            host_irq_b_n,
  output logic            serr_in_n,
  output logic            serr_drive,
  output logic            perr_in_n,
  output logic            perr_drive,
  output logic            master_abort,
  output logic            tabort_master,
  output logic            tabort_target
);
  // The link clock runs free, so slow host levels are always sampled.
  initial begin
    pci_clk = 1'b0;
    #3;
    forever #62.5 pci_clk = ~pci_clk;
  end
  assign tabort_target = ev[0];
  assign tabort_master = ev[1];
  assign master_abort  = ev[2];
  assign perr_in_n     = ~ev[3];
  assign serr_drive    = ev[4];
  assign serr_in_n     = ~ev[5];
  assign perr_drive    = ev[6];
  assign host_irq_a_n  = ~ev[7];
  assign host_irq_b_n  = ~ev[8];
  assign host_wake_n   = ~ev[9];
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import ahbpw_pkg::*;
  localparam logic [31:0] ADR [8] = '{ADDR_IN1, ADDR_IN2, ADDR_OUT1, ADDR_OUT2,
                                      ADDR_IEN, ADDR_BUS, ADDR_SETUP, ADDR_IST};
  localparam logic [31:0] MSK [8] = '{IN_WMASK, IN_WMASK, OUT1_WMASK, OUT2_WMASK,
                                      IEN_WMASK, BUS_WMASK, SETUP_WMASK, 32'h0};
  localparam int BITN [12] = '{0, 1, 2, 3, 4, 5, 3, 16, 17, 19, 12, 13};
  logic          ref_clk, nrst, ce, reg_wr, reg_rd, pci_clk, irq;
  logic [31:0]   reg_addr, reg_wdata, reg_rdata, in_addr, in_ahb_addr;
  logic [31:0]   ob_addr, ob_pci_addr;
  logic          host_wake_n, host_irq_a_n, host_irq_b_n, serr_in_n, serr_drive;
  logic          perr_in_n, perr_drive, master_abort, tabort_master, tabort_target;
  logic          in_bus_err, in_bus_err_win2, in_req, in_win2, in_ack, in_ok;
  ahbpw_endian_t in_endian;
  logic [4:0]    in_max_beats, m_beats;
  logic          ob_req, ob_win2, ob_ack, ob_ok, s_busy, s_hready;
  logic [2:0]    ob_cmd, m_size, hburst;
  logic          m_start, m_want, m_more, hgrant, hready, hbusreq;
  logic [1:0]    htrans;
  logic [9:0]    ev;
  integer        seed, miscompares, tests_run, cyc;

  ahbpw_ctrl i_ahbpw_ctrl (
    .ref_clk         (ref_clk),
    .nrst            (nrst),
    .ce              (ce),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_rdata       (reg_rdata),
    .pci_clk         (pci_clk),
    .host_wake_n     (host_wake_n),
    .host_irq_a_n    (host_irq_a_n),
    .host_irq_b_n    (host_irq_b_n),
    .serr_in_n       (serr_in_n),
    .serr_drive      (serr_drive),
    .perr_in_n       (perr_in_n),
    .perr_drive      (perr_drive),
    .master_abort    (master_abort),
    .tabort_master   (tabort_master),
    .tabort_target   (tabort_target),
    .in_bus_err      (in_bus_err),
    .in_bus_err_win2 (in_bus_err_win2),
    .irq             (irq),
    .in_req          (in_req),
    .in_win2         (in_win2),
    .in_addr         (in_addr),
    .in_ack          (in_ack),
    .in_ok           (in_ok),
    .in_ahb_addr     (in_ahb_addr),
    .in_endian       (in_endian),
    .in_max_beats    (in_max_beats),
    .ob_req          (ob_req),
    .ob_win2         (ob_win2),
    .ob_addr         (ob_addr),
    .ob_ack          (ob_ack),
    .ob_ok           (ob_ok),
    .ob_pci_addr     (ob_pci_addr),
    .ob_cmd          (ob_cmd),
    .s_busy          (s_busy),
    .s_hready        (s_hready),
    .m_start         (m_start),
    .m_beats         (m_beats),
    .m_size          (m_size),
    .m_want          (m_want),
    .m_more          (m_more),
    .hgrant          (hgrant),
    .hready          (hready),
    .hbusreq         (hbusreq),
    .htrans          (htrans),
    .hburst          (hburst)
  );
  ahbpw_host_model i_ahbpw_host_model (
    .ev              (ev),
    .pci_clk         (pci_clk),
    .host_wake_n     (host_wake_n),
    .host_irq_a_n    (host_irq_a_n),
    .host_irq_b_n    (host_irq_b_n),
    .serr_in_n       (serr_in_n),
    .serr_drive      (serr_drive),
    .perr_in_n       (perr_in_n),
    .perr_drive      (perr_drive),
    .master_abort    (master_abort),
    .tabort_master   (tabort_master),
    .tabort_target   (tabort_target)
  );

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Hangs are cut short here rather than by a wall-clock limit.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rc(input logic [31:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  function automatic logic [2:0] exp_burst(input logic [4:0] n, input logic [2:0] sz);
    if (sz < 3'd2) return HBURST_SINGLE;
    if (n >= 5'd16) return HBURST_INCR16;
    if (n >= 5'd8) return HBURST_INCR8;
    if (n >= 5'd4) return HBURST_INCR4;
    if (n >= 5'd2) return HBURST_INCR;
    return HBURST_SINGLE;
  endfunction

  initial begin
    logic [31:0] a, b, d, m;
    logic [2:0]  sz;
    int          i;
    seed = 32'he551;
    miscompares = 0;
    tests_run = 0;
    cyc = 0;
    {nrst, reg_wr, reg_rd, in_bus_err, in_bus_err_win2, in_req, in_win2} = '0;
    {ob_req, ob_win2, s_busy, m_start, m_want, m_more, hgrant, hready} = '0;
    {reg_addr, reg_wdata, in_addr, ob_addr, m_beats, m_size, ev} = '0;
    ce = 1'b1;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    #1 chk(irq, 1'b0);
    for (i = 0; i < 8; i++) rc(ADR[i], RST_VAL);
    rc(32'h4003_0828, 32'h0);
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      wr(ADR[i], d);
      rc(ADR[i], d & MSK[i]);
    end
    wr(32'h4003_0828, 32'hffff_ffff);
    rc(32'h4003_0828, 32'h0);
    wr(ADDR_BUS, BUS_WMASK);
    for (i = 0; i < 16; i++) begin
      a = $random(seed);
      b = $random(seed);
      d = $random(seed);
      wr(ADDR_SETUP, {20'h0, d[6:5], d[7], 9'h0});
      wr(i[0] ? ADDR_IN2 : ADDR_IN1, {b[31:28], 19'h0, i[3:1], 4'h0, d[4:3]});
      in_win2 <= i[0];
      in_addr <= a;
      in_req  <= 1'b1;
      @(posedge ref_clk);
      in_req <= 1'b0;
      #1 m = i[0] ? WIN1_MASK_BASE : WIN1_MASK_BASE << d[6:5];
      chk(in_ack, 1'b1);
      chk(in_ok, (i[3:1] <= 3'd4) && (!i[0] || d[7]));
      if (in_ok === 1'b1) begin
        chk(in_ahb_addr, (b & m) | (a & ~m));
        chk(in_endian, i[3:1]);
        chk(in_max_beats, (d[4:3] == PREFETCH_ON) ? 5'd16 : 5'd1);
      end
    end
    for (i = 0; i < 16; i++) begin
      a = $random(seed);
      b = $random(seed);
      wr(i[0] ? ADDR_OUT2 : ADDR_OUT1, {b[31:11], 7'h0, i[3:1], 1'b0});
      ob_win2 <= i[0];
      ob_addr <= a;
      ob_req  <= 1'b1;
      @(posedge ref_clk);
      ob_req <= 1'b0;
      #1 m = i[0] ? 32'hffff_0000 : 32'hffff_f800;
      chk(ob_ack, 1'b1);
      chk(ob_ok, i[0] ? i[3:1] == CMD_MEMORY : i[3:1] == CMD_CONFIG);
      if (ob_ok === 1'b1) begin
        chk(ob_pci_addr, (b & m) | (a & ~m));
        chk(ob_cmd, i[3:1]);
      end
    end
    wr(ADDR_IEN, 32'h0);
    in_bus_err <= 1'b1;
    tk(1);
    in_bus_err <= 1'b0;
    tk(2);
    rc(ADDR_IST, 32'h1 << FLG_IN1_ERR);
    chk(irq, 1'b0);
    wr(ADDR_IEN, IEN_WMASK);
    tk(2);
    chk(irq, 1'b1);
    wr(ADDR_IST, 32'h1 << FLG_IN1_ERR);
    for (i = 0; i < 12; i++) begin
      if (i < 10)
        ev <= 10'h1 << i;
      else begin
        in_bus_err_win2 <= i[0];
        in_bus_err      <= 1'b1;
      end
      tk(1);
      in_bus_err <= 1'b0;
      tk(24);
      rc(ADDR_IST, 32'h1 << BITN[i]);
      chk(irq, 1'b1);
      ev <= '0;
      tk(8);
      // Host bits follow their pins, so they read back as zero once released.
      b = (i > 6 && i < 10) ? 32'h0 : 32'h1 << BITN[i];
      wr(ADDR_IST, ~b);
      rc(ADDR_IST, b);
      wr(ADDR_IST, b);
      rc(ADDR_IST, 32'h0);
      tk(1);
      chk(irq, 1'b0);
    end
    hgrant <= 1'b1;
    hready <= 1'b1;
    for (i = 0; i < 24; i++) begin
      d = $random(seed);
      sz = (d[6:5] == 2'd3) ? 3'd2 : {1'b0, d[6:5]};
      m_beats <= d[4] ? 5'd16 : {1'b0, d[3:0]};
      m_size  <= sz;
      m_start <= 1'b1;
      @(posedge ref_clk);
      m_start <= 1'b0;
      #1 chk(hburst, exp_burst(d[4] ? 5'd16 : {1'b0, d[3:0]}, sz));
      chk(htrans, HTRANS_NONSEQ);
      tk(1);
      chk(htrans, HTRANS_IDLE);
    end
    hgrant <= 1'b0;
    m_want <= 1'b1;
    tk(3);
    chk(hbusreq, 1'b1);
    hgrant <= 1'b1;
    tk(1);
    chk(hbusreq, 1'b0);
    hgrant <= 1'b0;
    m_more <= 1'b1;
    tk(2);
    hgrant <= 1'b1;
    tk(1);
    chk(hbusreq, 1'b1);
    m_want <= 1'b0;
    s_busy <= 1'b1;
    #1 chk(s_hready, 1'b0);
    s_busy <= 1'b0;
    #1 chk(s_hready, 1'b1);
    // A write while the clock enable is low must leave the register alone.
    ce <= 1'b0;
    wr(ADDR_IEN, 32'h0);
    ce <= 1'b1;
    rc(ADDR_IEN, IEN_WMASK);
    tk(2);
    tally_and_finish();
  end
endmodule
